//--- core/sdsc_detect.v
// Threshold comparator with range factor scaling
`timescale 1ns/1ps
`default_nettype none

module sdsc_detect (
    input wire [15:0] value_i,     // Measured detector value
    input wire [1:0] factor_i,     // Range factor code
    input wire [5:0] threshold_i,  // Threshold level
    input wire enable_i,           // Comparison armed
    output wire hit_o              // Value above threshold
);

    reg [15:0] scaled;

    // RQ11 range factor divide
    always @* begin
        case (factor_i)
            2'h0: scaled = value_i >> 2;
            2'h1: scaled = value_i >> 4;
            2'h2: scaled = value_i >> 6;
            2'h3: scaled = value_i >> 8;
            default: scaled = value_i;
        endcase
    end

    // Strictly above threshold only
    assign hit_o = enable_i && (scaled > {10'h000, threshold_i});

endmodule

`default_nettype wire

//--- core/sdsc_regs.vh
// Register indices, field positions and reset values of the detector configuration bank
`ifndef SDSC_REGS_VH
`define SDSC_REGS_VH

// Register indices; byte address is four times the index
`define SDSC_IDX_LOW_LEVEL_A 8'hb6
`define SDSC_IDX_LOW_LEVEL_B 8'hb7
`define SDSC_IDX_RANGE_A 8'hb8
`define SDSC_IDX_RANGE_B 8'hb9
`define SDSC_IDX_WAKEUP_A 8'hc0
`define SDSC_IDX_WAKEUP_B 8'hc1
`define SDSC_IDX_PRESLC_A 8'hc2
`define SDSC_IDX_PRESLC_B 8'hc3
`define SDSC_IDX_STATUS 8'hc4

// Reset values
`define SDSC_RST_LOW_LEVEL 8'h00
`define SDSC_RST_WAKEUP 8'h00
`define SDSC_RST_PRESLC 8'h80
`define SDSC_RST_RANGE 8'h08

// Wake-up detector fields
`define SDSC_WU_CNT_HI 7
`define SDSC_WU_CNT_LO 6
`define SDSC_WU_THR_HI 5
`define SDSC_WU_THR_LO 0

// Pre-slicer fields
`define SDSC_PS_OFF_BIT 7
`define SDSC_PS_HYS_HI 6
`define SDSC_PS_HYS_LO 5
`define SDSC_PS_THR_HI 4
`define SDSC_PS_THR_LO 0

// Low-level detector fields
`define SDSC_LL_SRC_BIT 7
`define SDSC_LL_MAN_BIT 6
`define SDSC_LL_THR_HI 5
`define SDSC_LL_THR_LO 0

// Range factor control field
`define SDSC_RF_HI 3
`define SDSC_RF_LO 2

// Noise detector configuration that arms the low-level threshold
`define SDSC_NDCFG_LOW_ON 2'h3

// Status register bit positions
`define SDSC_ST_SIG_DET 0
`define SDSC_ST_LOW_DET 1
`define SDSC_ST_RF_LO 2
`define SDSC_ST_RF_HI 3
`define SDSC_ST_PS_EN 4
`define SDSC_ST_SET_B 5

`endif

//--- core/sdsc_top.v
// Signal detector and pre-slicer configuration bank with AHB-Lite register port
//
// Functional notes
// RQ1: Software sets wake-up threshold counter bits 7:6 to 00b, counter disabled.
// RQ2: Device holds six-bit wake-up threshold level in bits 5:0.
// RQ3: Pre-slicer control bit 7: 0 enables, 1 disables; disabled by default.
// RQ4: Software enables pre-slicer only in gap-protocol framing with standard settings.
// RQ5: Software sets pre-slicer hysteresis bits 6:5 to 01b.
// RQ6: Software sets pre-slicer threshold bits 4:0 to 10010b.
// RQ7: Low-level bit 7 selects noise statistic: 0 ASK noise, 1 FSK deviation signal.
// RQ8: Low-level bit 6 clear: range factor taken automatically from data rate.
// RQ9: Low-level bit 6 set: range factor taken from range-selection control register.
// RQ10: Low-level threshold acts only when noise detector configuration is 11b.
// RQ11: Range codes 0..3 mean factors 2,4,6,8; value divided by 2^factor; default 10b.
// RQ12: Signal reported only when scaled value exceeds active-mode threshold.
`timescale 1ns/1ps
`default_nettype none
`include "sdsc_regs.vh"

module sdsc_top (
    input wire core_clk_i,              // 10 MHz clock
    input wire rst_i,                   // Async reset, active high
    input wire hsel_i,                  // AHB slave select
    input wire [31:0] haddr_i,          // AHB address
    input wire [1:0] htrans_i,          // AHB transfer type
    input wire hwrite_i,                // AHB write
    input wire [2:0] hsize_i,           // AHB size
    input wire [31:0] hwdata_i,         // AHB write data
    input wire hready_i,                // AHB ready in
    output reg [31:0] hrdata_o,         // AHB read data
    output reg hreadyout_o,             // AHB ready out
    output reg hresp_o,                 // AHB response, always OKAY
    input wire set_b_i,                 // Use configuration set B
    input wire wake_mode_i,             // Wake-up mode active
    input wire [5:0] run_threshold_i,   // Run mode threshold level
    input wire [1:0] rate_factor_i,     // Range factor derived from data rate
    input wire [1:0] noise_det_cfg_i,   // Noise detector configuration
    input wire [15:0] detector_value_i, // Measured detector value
    input wire [7:0] ask_noise_i,       // ASK noise power statistic
    input wire [7:0] fsk_dev_sig_i,     // Signal for minimum FSK deviation
    output reg sig_detect_o,            // Signal detected
    output reg low_detect_o,            // Low-level threshold exceeded
    output reg [7:0] noise_stat_o,      // Selected noise statistic
    output reg [1:0] range_factor_o,    // Active range factor code
    output reg [1:0] detect_cnt_o,      // Wake-up threshold counter setting
    output reg pre_slicer_en_o,         // Pre-slicer enabled
    output reg [1:0] pre_slicer_hyst_o, // Pre-slicer hysteresis
    output reg [4:0] pre_slicer_thr_o   // Pre-slicer threshold
);

    // Word index of a byte address
    function [7:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    reg [7:0] low_level_a_r;
    reg [7:0] low_level_b_r;
    reg [7:0] wakeup_a_r;
    reg [7:0] wakeup_b_r;
    reg [7:0] pre_slicer_a_r;
    reg [7:0] pre_slicer_b_r;
    reg [7:0] range_a_r;
    reg [7:0] range_b_r;
    reg wr_pend_r;
    reg [7:0] wr_idx_r;
    reg [31:0] rd_nxt;
    reg [7:0] status;
    wire addr_phase;
    wire [7:0] low_level;
    wire [7:0] wakeup;
    wire [7:0] pre_slicer;
    wire [7:0] range_ctl;
    wire [1:0] factor;
    wire [5:0] active_thr;
    wire low_armed;
    wire sig_hit;
    wire low_hit;

    // Valid transfer in address phase
    assign addr_phase = hsel_i && htrans_i[1] && hready_i;

    // Active configuration set
    assign low_level = set_b_i ? low_level_b_r : low_level_a_r;
    assign wakeup = set_b_i ? wakeup_b_r : wakeup_a_r;
    assign pre_slicer = set_b_i ? pre_slicer_b_r : pre_slicer_a_r;
    assign range_ctl = set_b_i ? range_b_r : range_a_r;

    // RQ8 RQ9 range factor source
    assign factor = low_level[`SDSC_LL_MAN_BIT] ? range_ctl[`SDSC_RF_HI:`SDSC_RF_LO] : rate_factor_i;

    // RQ2 RQ12 mode threshold choice
    assign active_thr = wake_mode_i ? wakeup[`SDSC_WU_THR_HI:`SDSC_WU_THR_LO] : run_threshold_i;

    // RQ10 low-level threshold arming
    assign low_armed = (noise_det_cfg_i == `SDSC_NDCFG_LOW_ON);

    // RQ11 RQ12 main detector comparison
    sdsc_detect u_sig_det (
        .value_i(detector_value_i),
        .factor_i(factor),
        .threshold_i(active_thr),
        .enable_i(1'b1),
        .hit_o(sig_hit)
    );

    // RQ10 low-level comparison
    sdsc_detect u_low_det (
        .value_i(detector_value_i),
        .factor_i(factor),
        .threshold_i(low_level[`SDSC_LL_THR_HI:`SDSC_LL_THR_LO]),
        .enable_i(low_armed),
        .hit_o(low_hit)
    );

    // Status word of the block's own state
    always @* begin
        status = 8'h00;
        status[`SDSC_ST_SIG_DET] = sig_detect_o;
        status[`SDSC_ST_LOW_DET] = low_detect_o;
        status[`SDSC_ST_RF_HI:`SDSC_ST_RF_LO] = range_factor_o;
        status[`SDSC_ST_PS_EN] = pre_slicer_en_o;
        status[`SDSC_ST_SET_B] = set_b_i;
    end

    // Read data; configuration registers are write-only and read zero
    always @* begin
        if (word_index(haddr_i) == `SDSC_IDX_STATUS) begin
            rd_nxt = {24'h000000, status};
        end else begin
            rd_nxt = 32'h00000000;
        end
    end

    // Bus slave: zero wait states, OKAY always
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_idx_r <= 8'h00;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_r <= addr_phase && hwrite_i;
            if (addr_phase) begin
                wr_idx_r <= word_index(haddr_i);
            end
            if (addr_phase && !hwrite_i) begin
                hrdata_o <= rd_nxt;
            end
        end
    end

    // Register writes in the data phase
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_level_a_r <= `SDSC_RST_LOW_LEVEL;
            low_level_b_r <= `SDSC_RST_LOW_LEVEL;
            wakeup_a_r <= `SDSC_RST_WAKEUP;
            wakeup_b_r <= `SDSC_RST_WAKEUP;
            // RQ3 pre-slicer off after reset
            pre_slicer_a_r <= `SDSC_RST_PRESLC;
            pre_slicer_b_r <= `SDSC_RST_PRESLC;
            // RQ11 default factor code 10b
            range_a_r <= `SDSC_RST_RANGE;
            range_b_r <= `SDSC_RST_RANGE;
        end else if (wr_pend_r) begin
            case (wr_idx_r)
                `SDSC_IDX_LOW_LEVEL_A: low_level_a_r <= hwdata_i[7:0];
                `SDSC_IDX_LOW_LEVEL_B: low_level_b_r <= hwdata_i[7:0];
                `SDSC_IDX_WAKEUP_A: wakeup_a_r <= hwdata_i[7:0];
                `SDSC_IDX_WAKEUP_B: wakeup_b_r <= hwdata_i[7:0];
                `SDSC_IDX_PRESLC_A: pre_slicer_a_r <= hwdata_i[7:0];
                `SDSC_IDX_PRESLC_B: pre_slicer_b_r <= hwdata_i[7:0];
                `SDSC_IDX_RANGE_A: range_a_r <= {4'h0, hwdata_i[`SDSC_RF_HI:`SDSC_RF_LO], 2'h0};
                `SDSC_IDX_RANGE_B: range_b_r <= {4'h0, hwdata_i[`SDSC_RF_HI:`SDSC_RF_LO], 2'h0};
                default: ;
            endcase
        end
    end

    // Registered block outputs
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sig_detect_o <= 1'b0;
            low_detect_o <= 1'b0;
            noise_stat_o <= 8'h00;
            range_factor_o <= 2'h2;
            detect_cnt_o <= 2'h0;
            pre_slicer_en_o <= 1'b0;
            pre_slicer_hyst_o <= 2'h0;
            pre_slicer_thr_o <= 5'h00;
        end else begin
            // RQ12 detection flags
            sig_detect_o <= sig_hit;
            low_detect_o <= low_hit;
            // RQ7 noise statistic source
            noise_stat_o <= low_level[`SDSC_LL_SRC_BIT] ? fsk_dev_sig_i : ask_noise_i;
            range_factor_o <= factor;
            // RQ1 counter setting passed to detector
            detect_cnt_o <= wakeup[`SDSC_WU_CNT_HI:`SDSC_WU_CNT_LO];
            // RQ3 active-low enable bit
            pre_slicer_en_o <= ~pre_slicer[`SDSC_PS_OFF_BIT];
            // RQ5 RQ6 hysteresis and threshold fields
            pre_slicer_hyst_o <= pre_slicer[`SDSC_PS_HYS_HI:`SDSC_PS_HYS_LO];
            pre_slicer_thr_o <= pre_slicer[`SDSC_PS_THR_HI:`SDSC_PS_THR_LO];
        end
    end

endmodule

`default_nettype wire

//--- tb/sdsc_chk.sv
// Port checker for the detector configuration bank
`timescale 1ns/1ps
`default_nettype none
module sdsc_chk (
    input wire logic core_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic hsel_i, // Select
    input wire logic [31:0] haddr_i, // Address
    input wire logic [1:0] htrans_i, // Transfer
    input wire logic hwrite_i, // Write
    input wire logic [31:0] hwdata_i, // Write data
    input wire logic hready_i, // Ready in
    input wire logic [31:0] hrdata_o, // Read data
    input wire logic hreadyout_o, // Ready out
    input wire logic hresp_o, // Response
    input wire logic set_b_i, // Set B
    input wire logic wake_mode_i, // Wake mode
    input wire logic [5:0] run_threshold_i, // Run level
    input wire logic [1:0] rate_factor_i, // Auto factor
    input wire logic [1:0] noise_det_cfg_i, // Noise cfg
    input wire logic [15:0] detector_value_i, // Value
    input wire logic [7:0] ask_noise_i, // ASK noise
    input wire logic [7:0] fsk_dev_sig_i, // FSK signal
    input wire logic sig_detect_o, // Detect
    input wire logic low_detect_o, // Low detect
    input wire logic [7:0] noise_stat_o, // Statistic
    input wire logic [1:0] range_factor_o, // Factor
    input wire logic [1:0] detect_cnt_o, // Counter
    input wire logic pre_slicer_en_o, // Slicer on
    input wire logic [1:0] pre_slicer_hyst_o, // Hysteresis
    input wire logic [4:0] pre_slicer_thr_o // Threshold
);
    logic [7:0] sh_r [0:255];
    logic [7:0] a_r, ll, rg, wk, ps, ns_x;
    logic w_r, sd_x, ld_x;
    logic [1:0] f;
    logic [15:0] v;
    logic [8:0] fx;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Shadow of written register bytes
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < 256; i++)
                sh_r[i] <= 8'h00;
            sh_r[8'hc2] <= 8'h80;
            sh_r[8'hc3] <= 8'h80;
            sh_r[8'hb8] <= 8'h08;
            sh_r[8'hb9] <= 8'h08;
            w_r <= 1'b0;
            a_r <= 8'h00;
        end else begin
            w_r <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            a_r <= haddr_i[9:2];
            if (w_r)
                sh_r[a_r] <= hwdata_i[7:0];
        end
    end
    // Expected outputs of the active set
    always_comb begin
        ll = sh_r[{7'h5b, set_b_i}];
        rg = sh_r[{7'h5c, set_b_i}];
        wk = sh_r[{7'h60, set_b_i}];
        ps = sh_r[{7'h61, set_b_i}];
        f = ll[6] ? rg[3:2] : rate_factor_i;
        v = detector_value_i >> (2 * (f + 1));
        sd_x = v > {10'h0, wake_mode_i ? wk[5:0] : run_threshold_i};
        ld_x = noise_det_cfg_i == 2'h3 && v > {10'h0, ll[5:0]};
        ns_x = ll[7] ? fsk_dev_sig_i : ask_noise_i;
        fx = {wk[7:6], ps[6:0]};
    end
    bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
    read_zero_a: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i[9:2] != 8'hc4
        |=> hrdata_o == 32'h0) else $error("write-only read not zero");
    slicer_en_a: assert property (!$past(rst_i) |-> pre_slicer_en_o == !$past(ps[7])) else $error("slicer enable");
    pass_fields_a: assert property (!$past(rst_i) |-> {detect_cnt_o, pre_slicer_hyst_o, pre_slicer_thr_o} == $past(fx))
        else $error("passed fields wrong");
    noise_src_a: assert property (!$past(rst_i) |-> noise_stat_o == $past(ns_x)) else $error("noise source");
    range_sel_a: assert property (!$past(rst_i) |-> range_factor_o == $past(f)) else $error("range factor");
    sig_detect_a: assert property (!$past(rst_i) |-> sig_detect_o == $past(sd_x)) else $error("signal detect");
    low_gate_a: assert property (!$past(rst_i) |-> low_detect_o == $past(ld_x)) else $error("low detect");
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the detector configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "sdsc_regs.vh"
module tb;
    logic core_clk_i, rst_i, hsel_i, hwrite_i, hready_i, set_b_i, wake_mode_i, hreadyout_o, hresp_o;
    logic sig_detect_o, low_detect_o, pre_slicer_en_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i, rate_factor_i, noise_det_cfg_i, range_factor_o, detect_cnt_o, pre_slicer_hyst_o;
    logic [2:0] hsize_i;
    logic [5:0] run_threshold_i;
    logic [15:0] detector_value_i;
    logic [7:0] ask_noise_i, fsk_dev_sig_i, noise_stat_o;
    logic [4:0] pre_slicer_thr_o;
    int failures, check_count;
    assign hready_i = hreadyout_o;
    sdsc_top dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .set_b_i(set_b_i), .wake_mode_i(wake_mode_i),
        .run_threshold_i(run_threshold_i), .rate_factor_i(rate_factor_i), .noise_det_cfg_i(noise_det_cfg_i),
        .detector_value_i(detector_value_i), .ask_noise_i(ask_noise_i), .fsk_dev_sig_i(fsk_dev_sig_i),
        .sig_detect_o(sig_detect_o), .low_detect_o(low_detect_o), .noise_stat_o(noise_stat_o),
        .range_factor_o(range_factor_o), .detect_cnt_o(detect_cnt_o), .pre_slicer_en_o(pre_slicer_en_o),
        .pre_slicer_hyst_o(pre_slicer_hyst_o), .pre_slicer_thr_o(pre_slicer_thr_o)
    );
    // Clock at 100 ns period
    initial begin
        core_clk_i = 0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel_i <= 1;
        htrans_i <= 2'h2;
        haddr_i <= {22'h0, idx, 2'h0};
        hwrite_i <= wr;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        hsel_i <= 0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1, idx, {24'h0, d}, x);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] x;
        bus(0, idx, 32'h0, x);
        chk("hrdata", x, e);
    endtask
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung bus
    initial begin
        #200us;
        failures++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        failures = 0;
        check_count = 0;
        rst_i = 1;
        hsel_i = 0;
        haddr_i = 0;
        htrans_i = 0;
        hwrite_i = 0;
        hsize_i = 3'h2;
        hwdata_i = 0;
        set_b_i = 0;
        wake_mode_i = 0;
        run_threshold_i = 6'h3f;
        rate_factor_i = 2'h2;
        noise_det_cfg_i = 0;
        detector_value_i = 0;
        ask_noise_i = 8'h11;
        fsk_dev_sig_i = 8'h22;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 0;
        tick(2);
        chk("slicer_en", pre_slicer_en_o, 0);
        rd_chk(`SDSC_IDX_STATUS, 32'h08);
        // Pre-slicer standard settings, set B stays disabled
        wr(`SDSC_IDX_PRESLC_A, 8'h32);
        tick(2);
        chk("slicer_en", pre_slicer_en_o, 1);
        chk("slicer_fld", {pre_slicer_hyst_o, pre_slicer_thr_o}, 7'h32);
        set_b_i <= 1;
        tick(2);
        chk("slicer_b", pre_slicer_en_o, 0);
        set_b_i <= 0;
        rd_chk(`SDSC_IDX_PRESLC_A, 0);
        rd_chk(8'h10, 0);
        // Manual range codes against the wake-up level
        wr(`SDSC_IDX_LOW_LEVEL_A, 8'h40);
        wr(`SDSC_IDX_WAKEUP_A, 8'h05);
        wake_mode_i <= 1;
        for (int c = 0; c < 4; c++) begin
            wr(`SDSC_IDX_RANGE_A, 8'(c << 2));
            detector_value_i <= 16'(5 << (2 * c + 2));
            tick(2);
            chk("range", range_factor_o, 32'(c));
            chk("no_det", sig_detect_o, 0);
            detector_value_i <= 16'(6 << (2 * c + 2));
            tick(2);
            chk("det", sig_detect_o, 1);
        end
        chk("cnt", detect_cnt_o, 0);
        // Noise source and low-level gate
        wr(`SDSC_IDX_LOW_LEVEL_A, 8'hc3);
        detector_value_i <= 16'h0400;
        noise_det_cfg_i <= 2'h2;
        tick(2);
        chk("noise", noise_stat_o, 8'h22);
        chk("low_off", low_detect_o, 0);
        noise_det_cfg_i <= 2'h3;
        tick(2);
        chk("low_on", low_detect_o, 1);
        rd_chk(`SDSC_IDX_STATUS, 32'h1e);
        // Automatic range from data rate
        wr(`SDSC_IDX_LOW_LEVEL_A, 8'h00);
        rate_factor_i <= 2'h1;
        wake_mode_i <= 0;
        detector_value_i <= 16'h03f0;
        tick(2);
        chk("auto", range_factor_o, 1);
        chk("noise", noise_stat_o, 8'h11);
        chk("run_no_det", sig_detect_o, 0);
        detector_value_i <= 16'h0400;
        tick(2);
        chk("run_det", sig_detect_o, 1);
        report_and_stop();
    end
endmodule
bind sdsc_top sdsc_chk u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .set_b_i(set_b_i), .wake_mode_i(wake_mode_i),
    .run_threshold_i(run_threshold_i), .rate_factor_i(rate_factor_i), .noise_det_cfg_i(noise_det_cfg_i),
    .detector_value_i(detector_value_i), .ask_noise_i(ask_noise_i), .fsk_dev_sig_i(fsk_dev_sig_i),
    .sig_detect_o(sig_detect_o), .low_detect_o(low_detect_o), .noise_stat_o(noise_stat_o),
    .range_factor_o(range_factor_o), .detect_cnt_o(detect_cnt_o), .pre_slicer_en_o(pre_slicer_en_o),
    .pre_slicer_hyst_o(pre_slicer_hyst_o), .pre_slicer_thr_o(pre_slicer_thr_o)
);
`default_nettype wire
